/* design/rpps_sequencer.v */
// Reset pin pulse sorter and power-up sequencer
`timescale 1ns/100ps
`default_nettype none
`include "rpps_regs.vh"
module rpps_sequencer #(
    // Cycles per microsecond first, so the product stays inside 32 bits
    parameter integer IF_READY_CYC  = `RPPS_IF_READY_US * (1000000 / `RPPS_CLK_PERIOD_PS),
    parameter integer REF_READY_CYC = `RPPS_REF_SETTLE_US * (1000000 / `RPPS_CLK_PERIOD_PS)
) (
    // Clock and reset (nrst is the supply power-on clear)
    input  wire                      clk,
    input  wire                      nrst,
    // Dual-function pin, active low
    input  wire                      powerdown_reset_pin_n,
    // Control register write from the serial interface
    input  wire                      ctrl_wr,
    input  wire [`RPPS_CTRL_W-1:0]   ctrl_wdata,
    // Raw digital inputs to be gated
    input  wire                      dig_in_activity,
    // Status
    output reg  [`RPPS_CTRL_W-1:0]   ctrl_q,
    output reg                       chip_reset_q,
    output reg                       powered_down_q,
    output reg                       temp_avg_en_q,
    output wire                      internal_ref_sel,
    output wire                      if_ready,
    output wire                      ref_ready,
    output wire                      dig_in_gated
);
    // Power-down bound rounds up so a 90 ns low is never cut short
    localparam integer PD_MIN_CYC = (`RPPS_PD_NS * 1000 + `RPPS_CLK_PERIOD_PS - 1) / `RPPS_CLK_PERIOD_PS;
    localparam integer CW         = 8;

    // Pin sorter states
    localparam [1:0] ST_RUN  = 2'b00;
    localparam [1:0] ST_LOW  = 2'b01;
    localparam [1:0] ST_DOWN = 2'b10;

    // Pin synchroniser; first stage read only by the second
    reg                     pin_s1_q;
    reg                     pin_s2_q;

    // Sorter state and low-time counter
    reg  [1:0]              state_q;
    reg  [1:0]              state_d;
    reg  [CW-1:0]           low_cnt_q;
    reg  [CW-1:0]           low_cnt_d;
    reg                     chip_reset_d;
    reg                     powered_down_d;
    reg                     restart_q;
    reg                     restart_d;

    // Sorter conditions
    wire                    pin_low;
    wire                    cnt_full;
    wire                    pd_reached;

    // Control register next values
    reg  [`RPPS_CTRL_W-1:0] ctrl_d;
    reg                     temp_avg_en_d;
    wire                    wr_take;

    // Idle level high, so no false edge follows reset
    always @(posedge clk) begin
        if (!nrst) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= powerdown_reset_pin_n;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign pin_low    = ~pin_s2_q;
    assign cnt_full   = (low_cnt_q == {CW{1'b1}});
    assign pd_reached = (low_cnt_q >= PD_MIN_CYC[CW-1:0]);

    // Low-time sorter; pulses under one cycle may be missed, a sampling limit
    always @* begin
        state_d        = state_q;
        low_cnt_d      = low_cnt_q;
        chip_reset_d   = chip_reset_q;
        powered_down_d = powered_down_q;
        restart_d      = 1'b0;
        case (state_q)
            ST_RUN: begin
                chip_reset_d   = 1'b0;
                powered_down_d = 1'b0;
                low_cnt_d      = {CW{1'b0}};
                if (pin_low) begin
                    state_d      = ST_LOW;
                    chip_reset_d = 1'b1;
                    low_cnt_d    = {{(CW-1){1'b0}}, 1'b1};
                end
            end
            ST_LOW: begin
                if (pin_low) begin
                    chip_reset_d = 1'b1;
                    if (!cnt_full) begin
                        low_cnt_d = low_cnt_q + {{(CW-1){1'b0}}, 1'b1};
                    end
                    // Mid band resolves by count: power-down once the count reaches the bound
                    if (pd_reached) begin
                        state_d        = ST_DOWN;
                        powered_down_d = 1'b1;
                    end
                end else begin
                    // Short pulse: reset only, waits rerun
                    state_d        = ST_RUN;
                    chip_reset_d   = 1'b0;
                    powered_down_d = 1'b0;
                    low_cnt_d      = {CW{1'b0}};
                    restart_d      = 1'b1;
                end
            end
            ST_DOWN: begin
                chip_reset_d   = 1'b1;
                powered_down_d = 1'b1;
                if (!pin_low) begin
                    // Release leaves power-down through a full restart
                    state_d        = ST_RUN;
                    chip_reset_d   = 1'b0;
                    powered_down_d = 1'b0;
                    low_cnt_d      = {CW{1'b0}};
                    restart_d      = 1'b1;
                end
            end
            default: begin
                state_d        = ST_RUN;
                chip_reset_d   = 1'b1;
                powered_down_d = 1'b0;
                low_cnt_d      = {CW{1'b0}};
                restart_d      = 1'b1;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state_q        <= ST_RUN;
            low_cnt_q      <= {CW{1'b0}};
            chip_reset_q   <= 1'b1;
            powered_down_q <= 1'b0;
            restart_q      <= 1'b1;
        end else begin
            state_q        <= state_d;
            low_cnt_q      <= low_cnt_d;
            chip_reset_q   <= chip_reset_d;
            powered_down_q <= powered_down_d;
            restart_q      <= restart_d;
        end
    end

    // Writes refused until the interface is up, and while held or powered down
    assign wr_take = ctrl_wr & if_ready & ~powered_down_q & ~chip_reset_q;

    // Control register, cleared by any pin reset
    always @* begin
        ctrl_d        = ctrl_q;
        temp_avg_en_d = temp_avg_en_q;
        if (chip_reset_q) begin
            ctrl_d        = `RPPS_CTRL_RESET;
            temp_avg_en_d = 1'b0;
        end else if (wr_take) begin
            ctrl_d        = ctrl_wdata;
            temp_avg_en_d = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            ctrl_q        <= `RPPS_CTRL_RESET;
            temp_avg_en_q <= 1'b0;
        end else begin
            ctrl_q        <= ctrl_d;
            temp_avg_en_q <= temp_avg_en_d;
        end
    end

    assign internal_ref_sel = ~ctrl_q[`RPPS_REFSEL_BIT];

    // Gated combinationally; activity during reset or power-down never reaches logic
    assign dig_in_gated     = dig_in_activity & ~powered_down_q & ~chip_reset_q;

    // Waits restart on power-on and after each pin pulse ends
    rpps_wait_timer #(
        .CYCLES (IF_READY_CYC),
        .W      (24)
    ) u_if_wait (
        .clk     (clk),
        .nrst    (nrst),
        .restart (restart_q),
        .done    (if_ready)
    );

    rpps_wait_timer #(
        .CYCLES (REF_READY_CYC),
        .W      (24)
    ) u_ref_wait (
        .clk     (clk),
        .nrst    (nrst),
        .restart (restart_q),
        .done    (ref_ready)
    );
endmodule
`default_nettype wire

/* design/rpps_regs.vh */
// Timing and reset constants for the reset pin and power-up sequencer
// Functional notes
// - Pin low under 60 ns gives reset only, never power-down.
// - Low between 60 and 90 ns resets; power-down entry is undefined.
// - Pin low longer than 90 ns enters power-down.
// - Power-on clear loads control register with all zeros.
// - All-zero control register selects internal reference mode.
// - Serial interface operational 500 us after power-up; host waits.
// - Reset restores control register defaults and disables temperature averaging.
// - In power-down, digital inputs other than the pin are ignored.
// - Pin acts asynchronously to serial clock, honoured at any time.
`ifndef RPPS_REGS_VH
`define RPPS_REGS_VH
`define RPPS_CLK_PERIOD_PS    10000
`define RPPS_RST_ONLY_NS      60
`define RPPS_PD_NS            90
`define RPPS_REF_SETTLE_US    5500
`define RPPS_IF_READY_US      500
`define RPPS_CTRL_W           16
`define RPPS_CTRL_RESET       16'h0000
`define RPPS_REFSEL_BIT       0
`endif

/* design/rpps_wait_timer.v */
// Down-counter that raises done after a programmable number of cycles
`timescale 1ns/100ps
`default_nettype none
module rpps_wait_timer #(
    parameter integer CYCLES = 16,
    parameter integer W      = 20
) (
    // Clock and reset
    input  wire         clk,
    input  wire         nrst,
    // Control
    input  wire         restart,
    output reg          done
);
    reg  [W-1:0] cnt_q;

    always @(posedge clk) begin
        if (!nrst || restart) begin
            cnt_q <= CYCLES[W-1:0];
            done  <= 1'b0;
        end else if (cnt_q > {{(W-1){1'b0}}, 1'b1}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end else begin
            done <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/rpps_sva.sv */
// Checker for the reset pin and power-up sequencer
`timescale 1ns/100ps
`default_nettype none
module rpps_sva (
    input wire logic        clk, nrst, powerdown_reset_pin_n, ctrl_wr, chip_reset_q, powered_down_q,
    input wire logic        temp_avg_en_q, internal_ref_sel, if_ready, dig_in_gated,
    input wire logic [15:0] ctrl_wdata, ctrl_q
);
    wire logic p = powerdown_reset_pin_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_short; $fell(p) ##1 !p [*3] ##1 p; endsequence
    sequence s_long; $fell(p) ##1 !p [*8] ##1 !p [*6]; endsequence
    short_no_pd_a: assert property (s_short |=> !powered_down_q [*8]) else $error("pd on short");
    long_pd_a: assert property (s_long |-> ##[0:4] powered_down_q) else $error("no pd");
    pin_reset_a: assert property ($fell(p) |-> ##[1:4] chip_reset_q) else $error("no reset");
    por_clear_a: assert property ($rose(nrst) |-> !ctrl_q && internal_ref_sel) else $error("por");
    reset_clear_a: assert property (chip_reset_q [*2] |-> !ctrl_q && !temp_avg_en_q) else $error("clr");
    pd_gate_a: assert property (powered_down_q |-> !dig_in_gated && !ctrl_q) else $error("gate");
    wr_take_a: assert property (ctrl_wr && if_ready && !powered_down_q && !chip_reset_q
        |=> ctrl_q == $past(ctrl_wdata)) else $error("wr");
    if_wait_a: assert property ($rose(nrst) |-> !if_ready [*8] ##[10:30] if_ready) else $error("if");
endmodule
bind rpps_sequencer rpps_sva i_sva (.*);
`default_nettype wire

/* tb/rpps_host.sv */
// Host model driving the pin and control writes
`timescale 1ns/100ps
`default_nettype none
module rpps_host (
    input  wire logic        clk,
    output var  logic        p_n = 1'b1,
    output var  logic        wr = 1'b0,
    output var  logic [15:0] wd = 16'h0000
);
    task write(logic [15:0] d); // Data not held after strobe
        @(posedge clk) {wr, wd} <= {1'b1, d};
        @(posedge clk) {wr, wd} <= {1'b0, ~d};
        #1;
    endtask
    task pin(logic v, int n); // Widths kept out of the ambiguous band
        @(posedge clk) p_n <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the reset pin and power-up sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 0, nrst = 0, p_n, wr, rq, pq, tq, isel, ifr, rfr, gq;
    logic [15:0] wd, cq;
    logic act = 1'b1;
    int err_count = 0, compares = 0;
    always #5 clk = ~clk;
    rpps_host i_host (.clk(clk), .p_n(p_n), .wr(wr), .wd(wd));
    rpps_sequencer #(.IF_READY_CYC(20), .REF_READY_CYC(40)) i_dut (.clk(clk), .nrst(nrst), .powerdown_reset_pin_n(p_n),
        .ctrl_wr(wr), .ctrl_wdata(wd), .dig_in_activity(act), .ctrl_q(cq), .chip_reset_q(rq), .powered_down_q(pq),
        .temp_avg_en_q(tq), .internal_ref_sel(isel), .if_ready(ifr), .ref_ready(rfr), .dig_in_gated(gq));
    task chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic await(ref logic s); // Bounded wait for a high level
        repeat (100) if (s !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        chk("wait", 1, s);
        if (s !== 1'b1) final_report;
    endtask
    task t_powerup; // Early write dropped, then taken
        @(posedge clk) nrst <= 1'b1;
        i_host.write(16'h0001);
        chk("ctrl", 0, cq);
        chk("iref", 1, isel);
        await(ifr);
        i_host.write(16'h0081);
        chk("ctrl", 16'h0081, cq);
        chk("iref", 0, isel);
        chk("rdy", 0, rfr);
        chk("avg", 1, tq);
        await(rfr);
    endtask
    task t_short; // 40 ns low gives reset only
        i_host.pin(0, 3);
        i_host.pin(1, 12);
        chk("pd", 0, pq);
        chk("ctrl", 0, cq);
        chk("avg", 0, tq);
        await(ifr);
    endtask
    task t_long; // 230 ns low, write ignored meanwhile
        i_host.write(16'h0003);
        i_host.pin(0, 20);
        chk("pd", 1, pq);
        chk("gate", 0, gq);
        i_host.write(16'h0005);
        chk("ctrl", 0, cq);
        i_host.pin(1, 5);
        await(ifr);
        i_host.write(16'h0002);
        chk("ctrl", 16'h0002, cq);
        chk("gate", 1, gq);
        @(posedge clk) act <= 1'b0;
        #1;
        chk("gate", 0, gq);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        t_powerup;
        t_short;
        t_long;
        final_report;
    end
endmodule
`default_nettype wire
